//--- verilog/tdc_regs.svh
// constant map of the two-row line combiner: offsets, fields, resets, timing
// assumes a 10 MHz pclk and a 12-bit pixel path
`ifndef TDC_REGS_SVH
`define TDC_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define TDC_CTRL_OFS 8'h00
`define TDC_EXPOSURE_OFS 8'h04
`define TDC_LINE_PERIOD_OFS 8'h08
`define TDC_SPATIAL_OFS 8'h0C
`define TDC_PERIOD_OFS 8'h10
`define TDC_INTEG_OFS 8'h14
`define TDC_LINE_COUNT_OFS 8'h18

// ****************************************
// control fields and reset values
// ****************************************
`define TDC_CTRL_AVG 0
`define TDC_CTRL_WIDE 1
`define TDC_CTRL_COLOUR 2
`define TDC_CTRL_GREEN_ONLY 3
`define TDC_CTRL_ROW2_FIXED 4
`define TDC_CTRL_MODE_LSB 5
`define TDC_CTRL_ENABLE 7
`define TDC_CTRL_RESET 8'h00
`define TDC_EXPOSURE_RESET 16'h0064
`define TDC_LINE_PERIOD_RESET 24'h0003E8
`define TDC_SPATIAL_RESET 8'h80
`define TDC_SPATIAL_MAX 8'hC0
`define TDC_SPATIAL_FRAC 7
`define TDC_STAGES 2

// ****************************************
// timing
// ****************************************
`define TDC_CLK_NS 100
`define TDC_EXTRA_NS 3200
`define TDC_ROW2_FIXED_NS 15000
`define TDC_EXTRA_CYC ((`TDC_EXTRA_NS + `TDC_CLK_NS - 1) / `TDC_CLK_NS)
`define TDC_ROW2_FIXED_CYC ((`TDC_ROW2_FIXED_NS + `TDC_CLK_NS - 1) / `TDC_CLK_NS)

`endif

//--- verilog/tdc_pkg.sv
// types shared by the line combiner modules
// assumes nothing beyond the constant header
package tdc_pkg;
    typedef logic [11:0] tdc_pix_type;
    typedef logic [23:0] tdc_count_type;
    typedef enum logic [1:0] {
        tdc_exp_timed = 2'h0,
        tdc_exp_prog_ext = 2'h1,
        tdc_exp_trig_width = 2'h2
    } tdc_exp_mode_type;
    typedef enum logic [1:0] {
        tdc_ro_idle = 2'b01,
        tdc_ro_busy = 2'b10
    } tdc_ro_state_type;
endpackage

//--- verilog/tdc_exp_if.sv
// exposure settings out to the timer, row pulses back
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface tdc_exp_if;
    logic trig_level;
    logic line_start;
    logic tw_mode;
    logic wide;
    logic row2_fixed;
    logic [15:0] exposure;
    tdc_pkg::tdc_count_type period;
    logic row1_exp;
    logic row2_exp;
    modport ctrl (output trig_level, line_start, tw_mode, wide, row2_fixed, exposure, period,
        input row1_exp, row2_exp);
    modport timer (input trig_level, line_start, tw_mode, wide, row2_fixed, exposure, period,
        output row1_exp, row2_exp);
endinterface
`default_nettype wire

//--- verilog/tdc_exposure_timer.sv
// row exposure pulse generator for both sensor rows
// assumes line_start is a one-cycle pulse and trig_level is already synchronised
`timescale 1ns/1ps
`default_nettype none
`include "tdc_regs.svh"
module tdc_exposure_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    tdc_exp_if.timer xif
);
    logic [15:0] w_cnt;
    logic [15:0] prog_w;
    logic row1;
    logic r1_d;
    logic rise;
    logic fall;
    tdc_pkg::tdc_count_type dly;
    tdc_pkg::tdc_count_type dly_load;
    tdc_pkg::tdc_count_type dly_r;
    tdc_pkg::tdc_count_type dly_f;
    logic row2_q;
    logic [15:0] hi_len;

    // ****************************************
    // row one pulse
    // ****************************************
    // sensor adds its own extra time, so the drive is shortened
    assign prog_w = (xif.exposure > 16'(`TDC_EXTRA_CYC)) ?
        16'(xif.exposure - 16'(`TDC_EXTRA_CYC)) : 16'h0001;
    assign row1 = xif.tw_mode ? xif.trig_level : (w_cnt != 16'h0000);
    assign rise = row1 & ~r1_d;
    assign fall = ~row1 & r1_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            w_cnt <= 16'h0000;
            r1_d <= 1'b0;
        end else if (ce) begin
            r1_d <= row1;
            if (xif.line_start && !xif.tw_mode) begin
                w_cnt <= prog_w;
            end else if (w_cnt != 16'h0000) begin
                w_cnt <= w_cnt - 16'h0001;
            end
        end
    end

    // ****************************************
    // row two stagger
    // ****************************************
    // both edges are delayed alike, except in trigger-width mode, where the rise uses the period from before line_start updates it
    assign dly = xif.row2_fixed ? 24'(`TDC_ROW2_FIXED_CYC) : (xif.period >> 1);
    assign dly_load = (dly < 24'h000002) ? 24'h000001 : dly - 24'h000001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_r <= 24'h000000;
            dly_f <= 24'h000000;
            row2_q <= 1'b0;
        end else if (ce) begin
            dly_r <= rise ? dly_load : ((dly_r != 24'h000000) ? dly_r - 24'h000001 : dly_r);
            dly_f <= fall ? dly_load : ((dly_f != 24'h000000) ? dly_f - 24'h000001 : dly_f);
            if (dly_r == 24'h000001) begin
                row2_q <= 1'b1;
            end else if (dly_f == 24'h000001) begin
                row2_q <= 1'b0;
            end
        end
    end

    assign xif.row1_exp = row1;
    assign xif.row2_exp = xif.wide ? row2_q : row1;

    // ****************************************
    // checks
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_len <= 16'h0000;
        end else if (ce) begin
            hi_len <= row1 ? hi_len + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    prog_width_a: assert property ($fell(row1) && !xif.tw_mode && $stable(xif.exposure)
        && xif.exposure > 16'(`TDC_EXTRA_CYC) |-> hi_len == prog_w)
        else $error("programmed exposure pulse width wrong");
    trig_width_a: assert property (xif.tw_mode |-> xif.row1_exp == xif.trig_level)
        else $error("trigger pulse not forwarded");
    stagger_fixed_a: assert property ($rose(row1) && xif.wide && xif.row2_fixed
        |-> ##150 $rose(xif.row2_exp))
        else $error("row two not delayed by fixed time");
    row2_follows_a: assert property ($rose(row1) && !xif.wide |-> $rose(xif.row2_exp))
        else $error("narrow rows not exposed together");
endmodule
`default_nettype wire

//--- verilog/tdc_line_combiner.sv
// two-row line combiner: exposure control, readout order, row combining
// assumes an APB master on pclk, pixel pairs arriving on pclk, trigger from a pin
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "tdc_regs.svh"
module tdc_line_combiner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_sync_trigger,
    output logic row1_exposure,
    output logic row2_exposure,
    output logic readout_start,
    output logic [1:0] readout_rows,
    input wire logic readout_done,
    input wire logic pix_valid,
    input wire logic pix_last,
    input wire tdc_pkg::tdc_pix_type pix_row1,
    input wire tdc_pkg::tdc_pix_type pix_row2,
    output logic out_valid,
    output logic out_last,
    output tdc_pkg::tdc_pix_type out_rb,
    output tdc_pkg::tdc_pix_type out_g
);
    logic [7:0] ctrl;
    logic [15:0] exposure;
    tdc_pkg::tdc_count_type line_period;
    logic [7:0] spatial;
    tdc_pkg::tdc_count_type period_q;
    tdc_pkg::tdc_count_type cnt_q;
    tdc_pkg::tdc_count_type timer;
    logic [15:0] line_count;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic r1_d;
    logic r2_d;
    logic pend1;
    logic pend2;
    tdc_pkg::tdc_ro_state_type ro_state;
    tdc_pkg::tdc_ro_state_type next_ro_state;
    logic [11:0] pix_idx;
    tdc_pkg::tdc_pix_type rb_mem [0:4095];

    tdc_exp_if xif ();

    // ****************************************
    // APB decode
    // ****************************************
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire sel_ctrl = paddr == `TDC_CTRL_OFS;
    wire sel_exp = paddr == `TDC_EXPOSURE_OFS;
    wire sel_lp = paddr == `TDC_LINE_PERIOD_OFS;
    wire sel_sp = paddr == `TDC_SPATIAL_OFS;
    wire sel_per = paddr == `TDC_PERIOD_OFS;
    wire sel_int = paddr == `TDC_INTEG_OFS;
    wire sel_lc = paddr == `TDC_LINE_COUNT_OFS;
    wire mapped = sel_ctrl | sel_exp | sel_lp | sel_sp | sel_per | sel_int | sel_lc;
    wire wr_en = access & pwrite & mapped;
    wire [24:0] integ = {period_q, 1'b0};
    wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl} :
        sel_exp ? {16'h0000, exposure} :
        sel_lp ? {8'h00, line_period} :
        sel_sp ? {24'h000000, spatial} :
        sel_per ? {8'h00, period_q} :
        sel_int ? {7'h00, integ} :
        sel_lc ? {16'h0000, line_count} : 32'h00000000;
    // factor above 1.5 would overshoot the alignment, so writes saturate
    wire [7:0] next_spatial = (pwdata[7:0] > `TDC_SPATIAL_MAX) ?
        `TDC_SPATIAL_MAX : pwdata[7:0];

    // zero wait states: read data is registered in the setup cycle
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `TDC_CTRL_RESET;
            exposure <= `TDC_EXPOSURE_RESET;
            line_period <= `TDC_LINE_PERIOD_RESET;
            spatial <= `TDC_SPATIAL_RESET;
            prdata <= 32'h00000000;
        end else if (ce) begin
            if (setup) begin
                prdata <= rd_mux;
            end
            if (wr_en && sel_ctrl) begin
                ctrl <= pwdata[7:0];
            end
            if (wr_en && sel_exp) begin
                exposure <= pwdata[15:0];
            end
            if (wr_en && sel_lp) begin
                line_period <= (pwdata[23:0] == 24'h000000) ? 24'h000001 : pwdata[23:0];
            end
            if (wr_en && sel_sp) begin
                spatial <= next_spatial;
            end
        end
    end

    // ****************************************
    // line trigger
    // ****************************************
    wire enable = ctrl[`TDC_CTRL_ENABLE];
    wire avg_sel = ctrl[`TDC_CTRL_AVG];
    wire wide = ctrl[`TDC_CTRL_WIDE];
    wire colour = ctrl[`TDC_CTRL_COLOUR];
    wire green_only = ctrl[`TDC_CTRL_GREEN_ONLY];
    wire [1:0] mode = ctrl[`TDC_CTRL_MODE_LSB +: 2];
    wire timed = mode == tdc_pkg::tdc_exp_timed;
    // two flops against metastability, the third only finds the edge
    wire trig_rise = trig_s2 & ~trig_s3;
    // a shortened period takes effect at once, the timer never runs past it
    wire timer_hit = timer >= line_period - 24'h000001;
    wire line_start = enable & (timed ? timer_hit : trig_rise);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else if (ce) begin
            trig_s1 <= line_sync_trigger;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end

    // previous period is kept for the half-period stagger and for status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer <= 24'h000000;
            cnt_q <= 24'h000000;
            period_q <= 24'h000000;
            line_count <= 16'h0000;
        end else if (ce) begin
            timer <= (!enable || !timed || timer_hit) ? 24'h000000 : timer + 24'h000001;
            if (line_start) begin
                cnt_q <= 24'h000001;
                period_q <= cnt_q;
                line_count <= line_count + 16'h0001;
            end else if (cnt_q != 24'hFFFFFF) begin
                cnt_q <= cnt_q + 24'h000001;
            end
        end
    end

    // ****************************************
    // exposure timer
    // ****************************************
    assign xif.trig_level = trig_s2 & enable;
    assign xif.line_start = line_start;
    assign xif.tw_mode = mode == tdc_pkg::tdc_exp_trig_width;
    assign xif.wide = wide;
    assign xif.row2_fixed = ctrl[`TDC_CTRL_ROW2_FIXED];
    assign xif.exposure = exposure;
    assign xif.period = period_q;

    tdc_exposure_timer u_timer (
        .pclk (pclk),
        .presetn (presetn),
        .ce (ce),
        .xif (xif.timer)
    );

    assign row1_exposure = xif.row1_exp;
    assign row2_exposure = xif.row2_exp;

    // ****************************************
    // readout order
    // ****************************************
    // integration of the next line may overlap a readout still running
    wire set1 = r1_d & ~row1_exposure;
    wire set2 = r2_d & ~row2_exposure;
    wire issue = (ro_state == tdc_pkg::tdc_ro_idle) & (pend1 | pend2);
    // wide sensor: row one first, row two waits for the readout to end
    wire [1:0] pick = !wide ? {pend2, pend1} : (pend1 ? 2'b01 : 2'b10);
    wire clr1 = issue & pick[0];
    wire clr2 = issue & pick[1];

    always_comb begin
        case (ro_state)
            tdc_pkg::tdc_ro_idle: next_ro_state = issue ? tdc_pkg::tdc_ro_busy : tdc_pkg::tdc_ro_idle;
            tdc_pkg::tdc_ro_busy: next_ro_state = readout_done ? tdc_pkg::tdc_ro_idle : tdc_pkg::tdc_ro_busy;
            default: next_ro_state = tdc_pkg::tdc_ro_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r1_d <= 1'b0;
            r2_d <= 1'b0;
            pend1 <= 1'b0;
            pend2 <= 1'b0;
            ro_state <= tdc_pkg::tdc_ro_idle;
            readout_start <= 1'b0;
            readout_rows <= 2'b00;
        end else if (ce) begin
            r1_d <= row1_exposure;
            r2_d <= row2_exposure;
            // a new exposure end beats a clear in the same cycle
            pend1 <= (pend1 & ~clr1) | set1;
            pend2 <= (pend2 & ~clr2) | set2;
            ro_state <= next_ro_state;
            readout_start <= issue;
            if (issue) begin
                readout_rows <= pick;
            end
        end
    end

    // ****************************************
    // pixel combining
    // ****************************************
    wire [12:0] sum13 = {1'b0, pix_row1} + {1'b0, pix_row2};
    wire [11:0] sum_sat = sum13[12] ? 12'hFFF : sum13[11:0];
    wire [11:0] avg = sum13[12:1];
    wire [11:0] prev_rb = rb_mem[pix_idx];
    // red/blue sits one trigger ahead of green; factor 1.0 takes the previous line
    wire signed [12:0] diff = $signed({1'b0, prev_rb}) - $signed({1'b0, pix_row1});
    wire signed [8:0] fct = $signed({1'b0, spatial});
    wire signed [21:0] prod = diff * fct;
    wire signed [21:0] algn = $signed({10'h000, pix_row1}) + (prod >>> `TDC_SPATIAL_FRAC);
    wire [11:0] aligned = algn[21] ? 12'h000 : ((algn > 22'sh000FFF) ? 12'hFFF : algn[11:0]);
    wire [11:0] mono = avg_sel ? avg : sum_sat;

    // no reset on the line memory: the first colour line aligns against junk
    always_ff @(posedge pclk) begin
        if (ce && pix_valid && colour) begin
            rb_mem[pix_idx] <= pix_row1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_idx <= 12'h000;
            out_valid <= 1'b0;
            out_last <= 1'b0;
            out_rb <= 12'h000;
            out_g <= 12'h000;
        end else if (ce) begin
            out_valid <= pix_valid;
            out_last <= pix_valid & pix_last;
            if (pix_valid) begin
                pix_idx <= pix_last ? 12'h000 : pix_idx + 12'h001;
                out_rb <= (colour && !green_only) ? aligned : 12'h000;
                out_g <= colour ? pix_row2 : mono;
            end
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn || !ce);

    sum_clamp_a: assert property (pix_valid && !colour && !avg_sel |=> out_valid &&
        (out_g == 12'hFFF || {1'b0, out_g} == {1'b0, $past(pix_row1)} + {1'b0, $past(pix_row2)}))
        else $error("summed pixel wrong or wrapped");
    avg_out_a: assert property (pix_valid && !colour && avg_sel |=>
        {1'b0, out_g} == (({1'b0, $past(pix_row1)} + {1'b0, $past(pix_row2)}) >> 1))
        else $error("averaged pixel wrong");
    integ_time_a: assert property (line_start ##1 !line_start |->
        integ == 25'(`TDC_STAGES * $past(cnt_q)))
        else $error("integration time not twice line period");
    spatial_range_a: assert property (spatial <= `TDC_SPATIAL_MAX)
        else $error("spatial factor out of range");
    one_row_read_a: assert property (readout_start && wide |-> readout_rows != 2'b11)
        else $error("both rows read at once on wide sensor");
    green_only_a: assert property (pix_valid && colour && green_only |=>
        out_rb == 12'h000 && out_g == $past(pix_row2))
        else $error("green channel not output alone");
    align_zero_a: assert property (pix_valid && colour && !green_only && spatial == 8'h00
        |=> out_rb == $past(pix_row1))
        else $error("zero factor must pass current red/blue");
    mono_rb_zero_a: assert property (pix_valid && !colour |=> out_rb == 12'h000)
        else $error("red/blue output not cleared in mono");
    line_count_a: assert property (line_start |=> line_count == $past(line_count) + 16'h0001)
        else $error("line not counted once per trigger");
    ro_one_pulse_a: assert property (readout_start |=> !readout_start)
        else $error("readout started twice in a row");
    // the frozen cycle is excluded by the default disable, so it has its own
    ce_freeze_a: assert property (disable iff (!presetn) !ce |=> $stable(out_valid) && $stable(pix_idx)
        && $stable(ro_state))
        else $error("state moved while clock enable low");

    // main scenarios: stagger, merged readout, clamp, external programmed, alignment
    wide_line_c: cover property (line_start && wide ##[1:600] $rose(row2_exposure));
    both_read_c: cover property (readout_start && readout_rows == 2'b11);
    clamp_hit_c: cover property (out_valid && out_g == 12'hFFF && !colour);
    ext_prog_c: cover property (line_start && mode == 2'b01);
    align_on_c: cover property (out_valid && colour && !green_only && spatial != 8'h00);
endmodule
`default_nettype wire

//--- verification/tdc_sensor_model.sv
// stand-in for the two-row sensor readout and the line trigger source
// assumes one pclk domain and a one-cycle readout_start pulse
`timescale 1ns/1ps
`default_nettype none
module tdc_sensor_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic readout_start,
    input wire logic slow,
    output logic readout_done,
    output logic line_sync_trigger
);
    // ****************************************
    // readout answer and trigger pulses
    // ****************************************
    int cnt;
    initial line_sync_trigger = 1'b0;
    // slow answers keep a row busy so a waiting row has to queue
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            readout_done <= 1'b0;
        end else begin
            readout_done <= 1'b0;
            if (readout_start && !slow) begin
                readout_done <= 1'b1;
            end else if (readout_start) begin
                cnt <= 6;
            end else if (cnt == 1) begin
                readout_done <= 1'b1;
                cnt <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
    // one pulse per pixel pitch of travel, width in cycles
    task automatic fire(input int w);
        @(posedge pclk);
        line_sync_trigger <= 1'b1;
        repeat (w) @(posedge pclk);
        line_sync_trigger <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verification/tb_tdc_line_combiner.sv
// self-checking bench for the two-row line combiner
// assumes tdc_regs.svh on the include path and the sensor model beside it
`timescale 1ns/1ps
`default_nettype none
`include "tdc_regs.svh"
module tb_tdc_line_combiner;
    // ****************************************
    // signals and instances
    // ****************************************
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, slv_v, ce;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_v;
    logic trig, row1, row2, ro_start, ro_done, slow, pv, pl, ov, ol, s;
    logic [1:0] ro_rows;
    tdc_pkg::tdc_pix_type p1, p2, orb, og;
    int err_total = 0;
    int n_tests = 0;
    int w, d;
    logic [1:0] ro_q[$];
    always #50 pclk = ~pclk;
    tdc_line_combiner dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_sync_trigger(trig), .row1_exposure(row1), .row2_exposure(row2), .readout_start(ro_start),
        .readout_rows(ro_rows), .readout_done(ro_done), .pix_valid(pv), .pix_last(pl), .pix_row1(p1),
        .pix_row2(p2), .out_valid(ov), .out_last(ol), .out_rb(orb), .out_g(og));
    tdc_sensor_model sens_u (.pclk(pclk), .presetn(presetn), .readout_start(ro_start), .slow(slow),
        .readout_done(ro_done), .line_sync_trigger(trig));
    always @(posedge pclk) if (ro_start === 1'b1) ro_q.push_back(ro_rows);
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic print_verdict;
        if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        for (t = 0; t < 20; t++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (t == 20) begin
            chk("pready", 1, 0);
            print_verdict;
        end
        rd_v = prdata;
        slv_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pix2(input tdc_pkg::tdc_pix_type a1, a2, b1, b2, ga, gb, ra, rb, input bit crb);
        @(posedge pclk);
        pv <= 1'b1;
        pl <= 1'b0;
        p1 <= a1;
        p2 <= a2;
        @(posedge pclk);
        pl <= 1'b1;
        p1 <= b1;
        p2 <= b2;
        #1;
        chk("out_valid", 1, ov);
        chk("out_g", ga, og);
        if (crb) chk("out_rb", ra, orb);
        @(posedge pclk);
        pv <= 1'b0;
        pl <= 1'b0;
        p1 <= ~b1;
        p2 <= ~b2;
        #1;
        chk("out_last", 1, ol);
        chk("out_g", gb, og);
        if (crb) chk("out_rb", rb, orb);
    endtask
    // width of row one and lag of row two, from a fresh row one rise
    task automatic expo;
        int t;
        int r1 = -1;
        int f1 = -1;
        int r2 = -1;
        logic q1 = row1;
        logic q2 = row2;
        s = 1'b1;
        for (t = 0; t < 3000 && (f1 < 0 || r2 < 0); t++) begin
            @(posedge pclk);
            #1;
            if (row1 && !q1 && r1 < 0) begin
                r1 = t;
                ro_q.delete();
            end
            if (!row1 && q1 && r1 >= 0) f1 = t;
            if (row2 && !q2 && r1 >= 0) r2 = t;
            if (row1 !== row2) s = 1'b0;
            q1 = row1;
            q2 = row2;
        end
        if (f1 < 0 || r2 < 0) begin
            chk("exposure_edges", 1, 0);
            print_verdict;
        end
        w = f1 - r1;
        d = r2 - r1;
    endtask
    task automatic ro_wait(input int n);
        for (int t = 0; t < 60 && ro_q.size() < n; t++) @(posedge pclk);
        chk("readout_count", 32'(n), 32'(ro_q.size()));
        if (ro_q.size() < n) print_verdict;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        apb(1'b0, `TDC_CTRL_OFS, 0);
        chk("ctrl", 0, rd_v);
        apb(1'b0, `TDC_EXPOSURE_OFS, 0);
        chk("exposure", 32'h64, rd_v);
        apb(1'b0, `TDC_LINE_PERIOD_OFS, 0);
        chk("line_period", 32'h3E8, rd_v);
        apb(1'b0, `TDC_SPATIAL_OFS, 0);
        chk("spatial", 32'h80, rd_v);
        apb(1'b0, 8'h1C, 0);
        chk("unmapped_rd", 0, rd_v);
        chk("unmapped_err", 1, slv_v);
    endtask
    task automatic t_mono;
        apb(1'b1, `TDC_CTRL_OFS, 32'h00);
        pix2(12'hBB8, 12'h7D0, 12'h064, 12'h0C8, 12'hFFF, 12'h12C, 0, 0, 1);
        apb(1'b1, `TDC_CTRL_OFS, 32'h01);
        pix2(12'hBB8, 12'h7D0, 12'hFFF, 12'hFFF, 12'h9C4, 12'hFFF, 0, 0, 1);
        // clock enable low must swallow a valid pixel
        @(posedge pclk);
        ce <= 1'b0;
        pv <= 1'b1;
        @(posedge pclk);
        ce <= 1'b1;
        pv <= 1'b0;
        #1;
        chk("ce_freeze", 0, ov);
    endtask
    task automatic t_timed;
        apb(1'b1, `TDC_EXPOSURE_OFS, 32'h28);
        apb(1'b1, `TDC_LINE_PERIOD_OFS, 32'hC8);
        apb(1'b1, `TDC_CTRL_OFS, 32'h80);
        expo;
        expo;
        chk("row1_width", 32'(40 - `TDC_EXTRA_CYC), 32'(w));
        chk("rows_together", 1, s);
        ro_wait(1);
        chk("rows_narrow", 2'b11, ro_q[0]);
        apb(1'b0, `TDC_PERIOD_OFS, 0);
        chk("period", 32'hC8, rd_v);
        apb(1'b0, `TDC_INTEG_OFS, 0);
        chk("integ", 32'(200 * `TDC_STAGES), rd_v);
    endtask
    task automatic t_wide;
        slow <= 1'b1;
        apb(1'b1, `TDC_CTRL_OFS, 32'h82);
        expo;
        expo;
        chk("row2_half", 32'(200 / 2), 32'(d));
        ro_wait(2);
        chk("ro_first", 2'b01, ro_q[0]);
        chk("ro_second", 2'b10, ro_q[1]);
        apb(1'b1, `TDC_CTRL_OFS, 32'h92);
        expo;
        expo;
        chk("row2_fixed", 32'(`TDC_ROW2_FIXED_CYC), 32'(d));
        slow <= 1'b0;
    endtask
    task automatic t_trig_width;
        logic [31:0] lc;
        apb(1'b1, `TDC_CTRL_OFS, 32'hA0);
        apb(1'b0, `TDC_LINE_COUNT_OFS, 0);
        lc = rd_v;
        fork
            sens_u.fire(20);
            expo;
        join
        chk("ext_prog_width", 32'(40 - `TDC_EXTRA_CYC), 32'(w));
        apb(1'b0, `TDC_LINE_COUNT_OFS, 0);
        chk("line_count", lc + 32'h1, rd_v);
        apb(1'b1, `TDC_CTRL_OFS, 32'hC0);
        fork
            sens_u.fire(20);
            expo;
        join
        chk("tw_width", 32'd20, 32'(w));
        chk("tw_together", 1, s);
        apb(1'b1, `TDC_CTRL_OFS, 32'h00);
    endtask
    task automatic t_colour;
        apb(1'b1, `TDC_CTRL_OFS, 32'h04);
        pix2(12'h00A, 12'h014, 12'h01E, 12'h028, 12'h014, 12'h028, 0, 0, 0);
        pix2(12'h064, 12'h0C8, 12'h12C, 12'h190, 12'h0C8, 12'h190, 12'h00A, 12'h01E, 1);
        apb(1'b1, `TDC_CTRL_OFS, 32'h0C);
        pix2(12'h064, 12'h0C8, 12'h12C, 12'h190, 12'h0C8, 12'h190, 0, 0, 1);
        apb(1'b1, `TDC_SPATIAL_OFS, 32'h00);
        apb(1'b1, `TDC_CTRL_OFS, 32'h04);
        pix2(12'h1F4, 12'h001, 12'h258, 12'h002, 12'h001, 12'h002, 12'h1F4, 12'h258, 1);
        apb(1'b1, `TDC_SPATIAL_OFS, 32'hFF);
        apb(1'b0, `TDC_SPATIAL_OFS, 0);
        chk("spatial_max", 32'hC0, rd_v);
        pix2(12'h2BC, 12'h001, 12'h384, 12'h002, 12'h001, 12'h002, 12'h190, 12'h1C2, 1);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pv = 1'b0;
        pl = 1'b0;
        p1 = 12'h000;
        p2 = 12'h000;
        slow = 1'b0;
        ce = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_mono;
        t_timed;
        t_wide;
        t_trig_width;
        t_colour;
        print_verdict;
    end
endmodule
`default_nettype wire
